// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;

	// ------------------------------------------------------------
	// Signals and design
	// ------------------------------------------------------------
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [17:0] s_axi_awaddr = 18'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [17:0] s_axi_araddr = 18'h0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic watchdog_disable = 1'b0;
	logic monitor_mode = 1'b0;
	logic break_active = 1'b0;
	logic wait_mode = 1'b0;
	logic stop_mode = 1'b0;
	logic vector_fetch = 1'b0;
	logic internal_reset = 1'b0;
	logic irq_pin_hv = 1'b0;
	logic rst_pin_hv = 1'b0;
	logic rst_pin_in = 1'b1;
	logic rst_pin_out;
	logic rst_pin_oe_n;
	logic wdog_sys_reset;
	logic wdog_cause;
	logic event_irq;
	int bad_count = 0;
	int total_checks = 0;
	logic [31:0] rd;
	logic [31:0] st;
	logic [1:0] rsp;
	logic [4:0] dis_cfg [4] = '{5'h10, 5'h0a, 5'h09, 5'h05};

	always #4 sys_clk = ~sys_clk;

	wdtc_watchdog #(.RST_VEC_LO(8'h5a)) i_wdtc_watchdog (.sys_clk(sys_clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.watchdog_disable(watchdog_disable), .monitor_mode(monitor_mode),
		.break_active(break_active), .wait_mode(wait_mode), .stop_mode(stop_mode),
		.vector_fetch(vector_fetch), .internal_reset(internal_reset), .irq_pin_hv(irq_pin_hv),
		.rst_pin_hv(rst_pin_hv), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
		.rst_pin_oe_n(rst_pin_oe_n), .wdog_sys_reset(wdog_sys_reset), .wdog_cause(wdog_cause),
		.event_irq(event_irq));

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic axi_write(input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (n < 1000) begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
			n++;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 1000) chk(32'h0, 32'h1);
	endtask

	task automatic axi_read(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (n < 1000) begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
			n++;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 1000) chk(32'h0, 32'h1);
	endtask

	task automatic service();
		logic [1:0] r;
		axi_write(wdtc_pkg::SERVICE_ADDR, 32'h0, r);
		chk({30'h0, r}, {30'h0, wdtc_pkg::RESP_OKAY});
	endtask

	task automatic test_done();
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge sys_clk);
		bad_count++;
		test_done();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4200) @(posedge sys_clk);
		axi_read(wdtc_pkg::STATE_ADDR, st, rsp);
		chk({31'h0, st[18:6] > 13'd60 && st[18:6] < 13'd300}, 32'h1);
		axi_read(wdtc_pkg::STATUS_ADDR, rd, rsp);
		service();
		axi_read(wdtc_pkg::STATE_ADDR, st, rsp);
		chk({26'h0, st[5:0]}, 32'h0);
		chk({31'h0, st[18:6] < 13'd32}, 32'h1);
		wait_mode <= 1'b1;
		repeat (4200) @(posedge sys_clk);
		axi_read(wdtc_pkg::STATE_ADDR, st, rsp);
		chk({26'h0, st[5:0]}, 32'h1);
		wait_mode <= 1'b0;
		foreach (dis_cfg[i]) begin
			{watchdog_disable, monitor_mode, break_active, irq_pin_hv, rst_pin_hv} <= dis_cfg[i];
			repeat (8) @(posedge sys_clk);
			service();
			repeat (4200) @(posedge sys_clk);
			axi_read(wdtc_pkg::STATE_ADDR, st, rsp);
			chk({26'h0, st[5:0]}, 32'h0);
			chk({31'h0, st[18:6] > 13'd4000}, 32'h1);
			{watchdog_disable, monitor_mode, break_active, irq_pin_hv, rst_pin_hv} <= 5'h0;
			repeat (8) @(posedge sys_clk);
		end
		axi_read(wdtc_pkg::STATE_ADDR, rd, rsp);
		vector_fetch <= 1'b1;
		@(posedge sys_clk);
		vector_fetch <= 1'b0;
		axi_read(wdtc_pkg::STATE_ADDR, st, rsp);
		chk({31'h0, st[18:6] < 13'd16}, 32'h1);
		chk({26'h0, st[5:0]}, {26'h0, rd[5:0]});
		repeat (4200) @(posedge sys_clk);
		internal_reset <= 1'b1;
		@(posedge sys_clk);
		internal_reset <= 1'b0;
		axi_read(wdtc_pkg::STATE_ADDR, st, rsp);
		chk({31'h0, st[18:6] < 13'd16}, 32'h1);
		chk({26'h0, st[5:0]}, 32'h0);
		service();
		stop_mode <= 1'b1;
		repeat (8) @(posedge sys_clk);
		axi_read(wdtc_pkg::STATE_ADDR, rd, rsp);
		repeat (200) @(posedge sys_clk);
		axi_read(wdtc_pkg::STATE_ADDR, st, rsp);
		chk({13'h0, st[18:0]}, {13'h0, rd[18:0]});
		stop_mode <= 1'b0;
		axi_read(wdtc_pkg::STATUS_ADDR, rd, rsp);
		chk({31'h0, rd[wdtc_pkg::EVT_STOP]}, 32'h1);
		service();
		repeat (3) @(posedge sys_clk);
		chk({31'h0, event_irq}, 32'h0);
		axi_write(wdtc_pkg::MASK_ADDR, 32'h2, rsp);
		repeat (3) @(posedge sys_clk);
		chk({31'h0, event_irq}, 32'h1);
		axi_read(wdtc_pkg::MASK_ADDR, rd, rsp);
		chk(rd, 32'h2);
		axi_write(wdtc_pkg::STATUS_ADDR, 32'h0, rsp);
		axi_read(wdtc_pkg::STATUS_ADDR, rd, rsp);
		chk({31'h0, rd[wdtc_pkg::EVT_SERVICE]}, 32'h1);
		repeat (3) @(posedge sys_clk);
		chk({31'h0, event_irq}, 32'h0);
		axi_read(wdtc_pkg::SERVICE_ADDR, rd, rsp);
		chk(rd, 32'h5a);
		chk({30'h0, rsp}, {30'h0, wdtc_pkg::RESP_OKAY});
		axi_read(18'h00010, rd, rsp);
		chk({rd[29:0], rsp}, {30'h0, wdtc_pkg::RESP_SLVERR});
		axi_write(18'h00010, 32'hff, rsp);
		chk({30'h0, rsp}, {30'h0, wdtc_pkg::RESP_SLVERR});
		axi_read(wdtc_pkg::CAUSE_ADDR, rd, rsp);
		chk(rd, 32'h0);
		chk({28'h0, rst_pin_oe_n, wdog_sys_reset, wdog_cause, rst_pin_out}, 32'h8);
		test_done();
	end

endmodule

// ---- wdtc_pin_sync.sv ----
`timescale 1ns/100ps
module wdtc_pin_sync #(
	parameter int W = 3
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= din;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A bit changes only once the two later stages agree
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dout <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (stage2[i] == stage3[i]) begin
					dout[i] <= stage3[i];
				end
			end
		end
	end

endmodule

// ---- wdtc_pkg.sv ----
package wdtc_pkg;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam int AXI_AW = 18;
	localparam logic [17:0] SERVICE_IDX = 18'h0ffff;
	localparam logic [17:0] SERVICE_ADDR = {SERVICE_IDX[15:0], 2'h0};
	localparam logic [17:0] STATUS_ADDR = 18'h00000;
	localparam logic [17:0] MASK_ADDR = 18'h00004;
	localparam logic [17:0] CAUSE_ADDR = 18'h00008;
	localparam logic [17:0] STATE_ADDR = 18'h0000c;

	// ---------------------------------------------------------------
	// Field layouts and reset values
	// ---------------------------------------------------------------
	localparam int EVT_W = 3;
	localparam int EVT_EXPIRE = 0;
	localparam int EVT_SERVICE = 1;
	localparam int EVT_STOP = 2;
	localparam logic [2:0] MASK_RST = 3'h0;
	localparam int CAUSE_WDOG_BIT = 0;
	localparam int STATE_WDOG_LSB = 0;
	localparam int STATE_PRESC_LSB = 6;
	localparam int STATE_RUN_BIT = 19;
	localparam int STATE_PIN_BIT = 20;
	localparam int STATE_STOP_BIT = 21;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// Counter structure and cycle counts (crystal clock cycles)
	// ---------------------------------------------------------------
	localparam int PRESC_W = 13;
	localparam int WDOG_W = 6;
	localparam logic [11:0] TICK_TAP = 12'hfff;
	localparam int WDOG_TIMEOUT_CYC = (2 ** 18) - (2 ** 4);
	localparam logic [11:0] EXPIRE_TAP = 12'(WDOG_TIMEOUT_CYC - ((2 ** 18) - (2 ** 12)));
	localparam logic [5:0] RST_PULSE_CYC = 6'h20;
	localparam logic [12:0] POR_CLR_CYC = 13'h1000;

endpackage

// ---- wdtc_watchdog.sv ----
// Summary of operation
// [RULE_01] Six-bit watchdog counter advances on carries of a 13-bit prescaler.
// [RULE_02] Unserviced, the watchdog expires after 2^18-2^4 clocks and forces reset.
// [RULE_03] Any write to the service register restarts the timeout.
// [RULE_04] Expiry holds the external reset pin low for 32 clocks.
// [RULE_05] Expiry sets the watchdog bit in the reset cause register.
// [RULE_06] Service write clears the watchdog counter and prescaler bits 12 to 4.
// [RULE_07] Reading the service register returns the reset vector low byte.
// [RULE_08] Prescaler is cleared once 4096 clocks after power-up.
// [RULE_09] Internal reset clears the prescaler and the watchdog counter.
// [RULE_10] Reset vector fetch clears the prescaler.
// [RULE_11] Disable input mirrors the option word's watchdog disable bit.
// [RULE_12] Watchdog expiry never requests a processor interrupt; it only resets. Here expiry sets EVT_EXPIRE, which raises event_irq when unmasked.
// [RULE_13] Monitor mode with test voltage on interrupt or reset pin disables it.
// [RULE_14] Watchdog keeps counting in wait mode.
// [RULE_15] Stop mode freezes the prescaler and so the watchdog.
// [RULE_16] Software should service just before and after stop mode.
// [RULE_17] Break with test voltage on the reset pin disables the watchdog.
// [RULE_18] Software should service from the main loop, not interrupt code.
// [RULE_19] Disable input high stops watchdog counting and expiry but not the prescaler; low lets it run.
`timescale 1ns/100ps
module wdtc_watchdog #(
	parameter logic [7:0] RST_VEC_LO = 8'h00
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [17:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [17:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic watchdog_disable,
	input wire logic monitor_mode,
	input wire logic break_active,
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic vector_fetch,
	input wire logic internal_reset,
	input wire logic irq_pin_hv,
	input wire logic rst_pin_hv,
	input wire logic rst_pin_in,
	output logic rst_pin_out,
	output logic rst_pin_oe_n,
	output logic wdog_sys_reset,
	output logic wdog_cause,
	output logic event_irq
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [2:0] pin_sync;
	logic irq_hv;
	logic rst_hv;
	logic rst_level;
	logic [wdtc_pkg::PRESC_W-1:0] presc;
	logic [wdtc_pkg::WDOG_W-1:0] wdog;
	logic [5:0] drv_cnt;
	logic [12:0] por_cnt;
	logic por_done;
	logic por_clear;
	logic run;
	logic tick;
	logic expire;
	logic svc_wr;
	logic stop_q;
	logic [wdtc_pkg::EVT_W-1:0] status;
	logic [wdtc_pkg::EVT_W-1:0] irq_mask;
	logic [wdtc_pkg::EVT_W-1:0] evt_set;
	logic [wdtc_pkg::EVT_W-1:0] next_status;
	logic aw_full;
	logic w_full;
	logic [17:0] aw_addr_q;
	logic [7:0] w_data_q;
	logic w_strb0_q;
	logic wr_do;
	logic aw_fire;
	logic w_fire;
	logic ar_fire;
	logic next_aw_full;
	logic next_w_full;
	logic next_rvalid;
	logic rd_status;
	logic rd_cause;

	function automatic logic reg_known(input logic [17:0] addr);
		reg_known = (addr == wdtc_pkg::SERVICE_ADDR) || (addr == wdtc_pkg::STATUS_ADDR) ||
			(addr == wdtc_pkg::MASK_ADDR) || (addr == wdtc_pkg::CAUSE_ADDR) ||
			(addr == wdtc_pkg::STATE_ADDR);
	endfunction

	// ---------------------------------------------------------------
	// Pin inputs
	// ---------------------------------------------------------------
	wdtc_pin_sync #(
		.W(3)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.din({rst_pin_in, rst_pin_hv, irq_pin_hv}),
		.dout(pin_sync)
	);

	assign irq_hv = pin_sync[0];
	assign rst_hv = pin_sync[1];
	assign rst_level = pin_sync[2];

	// ---------------------------------------------------------------
	// Run qualification and counter events
	// ---------------------------------------------------------------
	// Option bit, monitor and break test-voltage conditions
	assign run = !watchdog_disable && !(monitor_mode && (irq_hv || rst_hv)) && // [RULE_11] [RULE_19] [RULE_13]
		!(break_active && rst_hv); // [RULE_17]
	// Wait mode is deliberately not a term here
	assign tick = run && !stop_mode && (presc[11:0] == wdtc_pkg::TICK_TAP); // [RULE_01] [RULE_14] [RULE_15]
	assign expire = run && !stop_mode && (wdog == '1) && (presc[11:0] == wdtc_pkg::EXPIRE_TAP) &&
		!svc_wr && !internal_reset; // [RULE_02]
	assign por_clear = !por_done && (por_cnt == (wdtc_pkg::POR_CLR_CYC - 13'h0001));
	assign svc_wr = wr_do && (aw_addr_q == wdtc_pkg::SERVICE_ADDR);

	// ---------------------------------------------------------------
	// Prescaler
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			presc <= '0;
		end else if (internal_reset || vector_fetch || por_clear) begin
			presc <= '0; // [RULE_09] [RULE_10] [RULE_08]
		end else if (svc_wr) begin
			presc <= {9'h000, presc[3:0]}; // [RULE_06]
		end else if (!stop_mode) begin
			presc <= presc + 13'h0001; // [RULE_15]
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			por_cnt <= '0;
			por_done <= 1'b0;
		end else if (!por_done) begin
			por_cnt <= por_cnt + 13'h0001;
			por_done <= por_clear; // [RULE_08]
		end
	end

	// ---------------------------------------------------------------
	// Watchdog counter
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdog <= '0;
		end else if (internal_reset || svc_wr || expire) begin
			wdog <= '0; // [RULE_09] [RULE_03] [RULE_06]
		end else if (tick) begin
			wdog <= wdog + 6'h01; // [RULE_01]
		end
	end

	// ---------------------------------------------------------------
	// Reset pin drive and cause
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pin_oe_n <= 1'b1;
			wdog_sys_reset <= 1'b0;
			drv_cnt <= '0;
			rst_pin_out <= 1'b0;
		end else if (expire && rst_pin_oe_n) begin
			rst_pin_oe_n <= 1'b0; // [RULE_02] [RULE_04]
			wdog_sys_reset <= 1'b1;
			drv_cnt <= wdtc_pkg::RST_PULSE_CYC - 6'h01;
		end else if (!rst_pin_oe_n) begin
			if (drv_cnt == 6'h00) begin
				rst_pin_oe_n <= 1'b1; // [RULE_04]
				wdog_sys_reset <= 1'b0;
			end else begin
				drv_cnt <= drv_cnt - 6'h01;
			end
		end
	end

	// Cause bit: set wins over the clearing read
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdog_cause <= 1'b0;
		end else if (expire) begin
			wdog_cause <= 1'b1; // [RULE_05]
		end else if (rd_cause) begin
			wdog_cause <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Event status, mask and interrupt
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_q <= 1'b0;
		end else begin
			stop_q <= stop_mode;
		end
	end

	always_comb begin
		evt_set = '0;
		evt_set[wdtc_pkg::EVT_EXPIRE] = expire;
		evt_set[wdtc_pkg::EVT_SERVICE] = svc_wr;
		evt_set[wdtc_pkg::EVT_STOP] = stop_mode && !stop_q;
		next_status = (rd_status ? '0 : status) | evt_set;
	end

	// Interrupt line reports unmasked events, expiry included; expiry also acts through reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= '0;
			event_irq <= 1'b0;
		end else begin
			status <= next_status;
			// Uses the mask as it stands after this edge
			event_irq <= |(next_status & ((wr_do && (aw_addr_q == wdtc_pkg::MASK_ADDR) &&
				w_strb0_q) ? w_data_q[wdtc_pkg::EVT_W-1:0] : irq_mask)); // [RULE_12]
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= wdtc_pkg::MASK_RST;
		end else if (wr_do && (aw_addr_q == wdtc_pkg::MASK_ADDR) && w_strb0_q) begin
			irq_mask <= w_data_q[wdtc_pkg::EVT_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite write channel
	// ---------------------------------------------------------------
	assign aw_fire = s_axi_awvalid && s_axi_awready;
	assign w_fire = s_axi_wvalid && s_axi_wready;
	assign wr_do = aw_full && w_full && !s_axi_bvalid;

	always_comb begin
		next_aw_full = wr_do ? 1'b0 : (aw_fire ? 1'b1 : aw_full);
		next_w_full = wr_do ? 1'b0 : (w_fire ? 1'b1 : w_full);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb0_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			s_axi_awready <= !next_aw_full;
			s_axi_wready <= !next_w_full;
			if (aw_fire) begin
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_data_q <= s_axi_wdata[7:0];
				w_strb0_q <= s_axi_wstrb[0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= wdtc_pkg::RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= reg_known(aw_addr_q) ? wdtc_pkg::RESP_OKAY : wdtc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read channel
	// ---------------------------------------------------------------
	assign ar_fire = s_axi_arvalid && s_axi_arready;
	assign rd_status = ar_fire && (s_axi_araddr == wdtc_pkg::STATUS_ADDR);
	assign rd_cause = ar_fire && (s_axi_araddr == wdtc_pkg::CAUSE_ADDR);
	assign next_rvalid = ar_fire || (s_axi_rvalid && !s_axi_rready);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= wdtc_pkg::RESP_OKAY;
		end else begin
			s_axi_rvalid <= next_rvalid;
			s_axi_arready <= !next_rvalid;
			if (ar_fire) begin
				s_axi_rdata <= '0;
				s_axi_rresp <= reg_known(s_axi_araddr) ? wdtc_pkg::RESP_OKAY :
					wdtc_pkg::RESP_SLVERR;
				unique case (s_axi_araddr)
					wdtc_pkg::SERVICE_ADDR: begin
						s_axi_rdata[7:0] <= RST_VEC_LO; // [RULE_07]
					end
					wdtc_pkg::STATUS_ADDR: begin
						s_axi_rdata[wdtc_pkg::EVT_W-1:0] <= status;
					end
					wdtc_pkg::MASK_ADDR: begin
						s_axi_rdata[wdtc_pkg::EVT_W-1:0] <= irq_mask;
					end
					wdtc_pkg::CAUSE_ADDR: begin
						s_axi_rdata[wdtc_pkg::CAUSE_WDOG_BIT] <= wdog_cause; // [RULE_05]
					end
					wdtc_pkg::STATE_ADDR: begin
						s_axi_rdata[wdtc_pkg::STATE_WDOG_LSB +: wdtc_pkg::WDOG_W] <= wdog;
						s_axi_rdata[wdtc_pkg::STATE_PRESC_LSB +: wdtc_pkg::PRESC_W] <= presc;
						s_axi_rdata[wdtc_pkg::STATE_RUN_BIT] <= run;
						s_axi_rdata[wdtc_pkg::STATE_PIN_BIT] <= rst_level;
						s_axi_rdata[wdtc_pkg::STATE_STOP_BIT] <= stop_mode;
					end
					default: begin
						s_axi_rdata <= '0;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	logic [6:0] drv_len;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			drv_len <= '0;
		end else if (!rst_pin_oe_n) begin
			drv_len <= drv_len + 7'h01;
		end else begin
			drv_len <= '0;
		end
	end

	sequence s_expire;
		expire && rst_pin_oe_n;
	endsequence

	sequence s_pin_low;
		!rst_pin_oe_n && wdog_sys_reset && wdog_cause;
	endsequence

	sequence s_svc_read;
		ar_fire && (s_axi_araddr == wdtc_pkg::SERVICE_ADDR);
	endsequence

	AST_EXPIRE_DRIVES_PIN: assert property (s_expire |=> s_pin_low) // [RULE_02]
		else $error("expiry did not drive reset pin and cause");

	AST_PULSE_LENGTH: assert property ($rose(rst_pin_oe_n) |-> drv_len == 7'h20) // [RULE_04]
		else $error("reset pin low time is not 32 cycles");

	AST_CAUSE_ON_RESET: assert property ($fell(rst_pin_oe_n) |-> wdog_cause) // [RULE_05]
		else $error("cause bit not set with watchdog reset");

	AST_SERVICE_CLEARS: assert property (svc_wr && !internal_reset && !vector_fetch && !por_clear
		|=> wdog == 6'h00 && presc[12:4] == 9'h000) // [RULE_03]
		else $error("service write did not clear counters");

	AST_READ_VECTOR: assert property (s_svc_read |=> s_axi_rvalid && s_axi_rdata == {24'h0, RST_VEC_LO}) // [RULE_07]
		else $error("service read did not return vector byte");

	AST_INTERNAL_CLEARS: assert property (internal_reset |=> presc == '0 && wdog == '0) // [RULE_09]
		else $error("internal reset did not clear counters");

	AST_VECTOR_FETCH: assert property (vector_fetch |=> presc == '0) // [RULE_10]
		else $error("vector fetch did not clear prescaler");

	AST_POR_CLEAR: assert property (!por_done && por_cnt == 13'h0fff |=> presc == '0 && por_done) // [RULE_08]
		else $error("prescaler not cleared after power-up count");

	AST_STOP_FREEZE: assert property (stop_mode && !internal_reset && !vector_fetch && !por_clear
		&& !svc_wr |=> $stable(presc) && $stable(wdog)) // [RULE_15]
		else $error("counters moved in stop mode");

	AST_DISABLED_NO_RESET: assert property (!run |=> !$fell(rst_pin_oe_n)) // [RULE_19]
		else $error("reset started while watchdog disabled");

	AST_WAIT_COUNTS: assert property (wait_mode && !stop_mode && !internal_reset && !vector_fetch
		&& !por_clear && !svc_wr |=> presc == $past(presc) + 13'h0001) // [RULE_14]
		else $error("prescaler stalled in wait mode");

	AST_MONITOR_DISABLE: assert property (monitor_mode && (irq_hv || rst_hv) |-> !run) // [RULE_13]
		else $error("watchdog ran in monitor mode with test voltage");

	AST_BREAK_DISABLE: assert property (break_active && rst_hv |-> !run && !tick) // [RULE_17]
		else $error("watchdog ran in break with test voltage");

	AST_IRQ_ONLY_UNMASKED: assert property (event_irq |-> |(status & irq_mask)) // [RULE_12]
		else $error("interrupt without unmasked status");

endmodule
